// File: rtl/scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// clock and timing figures
`define SCS_CLK_NS            10
`define SCS_SYNC_PULSE_NS     500
`define SCS_SYNC_PULSE_CYC    (`SCS_SYNC_PULSE_NS / `SCS_CLK_NS)
`define SCS_MIN_ON_NS         45
`define SCS_MIN_ON_CYC        ((`SCS_MIN_ON_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_LOCK_FMAX_KHZ     500
`define SCS_LOCK_FMIN_KHZ     85
`define SCS_PER_MIN_CYC       (1000000 / (`SCS_LOCK_FMAX_KHZ * `SCS_CLK_NS))
`define SCS_PER_MAX_CYC       (1000000 / (`SCS_LOCK_FMIN_KHZ * `SCS_CLK_NS))
`define SCS_REF_TIMEOUT_CYC   (2 * `SCS_PER_MAX_CYC)
`define SCS_FREERUN_KHZ       40
`define SCS_FREERUN_PER_CYC   (1000000 / (`SCS_FREERUN_KHZ * `SCS_CLK_NS))
`define SCS_LOCK_TOL_CYC      4
`define SCS_LOCK_EDGES        4

// register byte offsets
`define SCS_ADR_CTRL          8'h00
`define SCS_ADR_NOMPER        8'h04
`define SCS_ADR_PHASE         8'h08
`define SCS_ADR_ONTIME        8'h0C
`define SCS_ADR_STATUS        8'h10
`define SCS_ADR_MASK          8'h14
`define SCS_ADR_PADS          8'h18
`define SCS_ADR_MEAS          8'h1C

// control bits
`define SCS_CTRL_RUN          0
`define SCS_CTRL_SYNC_OUT     1
`define SCS_CTRL_EXT_ONLY     2

// status and mask bits
`define SCS_ST_REF_LOST       0
`define SCS_ST_CLASH          1
`define SCS_ST_LOCK_LOST      4
`define SCS_ST_W              5

// pad state bits
`define SCS_PAD_REF_PRESENT   0
`define SCS_PAD_LOCKED        1
`define SCS_PAD_DRIVING       2
`define SCS_PAD_CLASH_N       10

// reset values
`define SCS_NOMPER_RST        16'h0190
`define SCS_ONTIME_RST        16'h0028
`define SCS_PHASE_RST         3'h0

`endif

// File: rtl/scs_pkg.sv
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_NOREF = 2'b00,
        SCS_ACQ   = 2'b01,
        SCS_LOCK  = 2'b10
    } scs_lock_e;

    typedef logic [15:0] scs_per_t;
endpackage

// File: rtl/scs_sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
module scs_sync_edge (
    // system
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin and edge
    input  wire logic pin_i,
    output logic      fall_o
);
    logic s1;
    logic s2;
    logic s3;

    // two-flop synchroniser, third stage only for edge finding
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // falling edges only; rising ones carry no phase
    assign fall_o = s3 & ~s2; // [R1]
endmodule
`default_nettype wire

// File: rtl/scs_phase_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "scs_regs.svh"
module scs_phase_gen (
    // system
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // oscillator state
    input  wire scs_pkg::scs_per_t cnt_i,
    input  wire scs_pkg::scs_per_t per_i,
    input  wire logic             run_i,
    // settings
    input  wire logic [2:0]       code_i,
    input  wire scs_pkg::scs_per_t on_time_i,
    // switch drive
    output logic [1:0]            pwm_o
);
    localparam logic [15:0] MIN_ON = 16'(`SCS_MIN_ON_CYC);

    logic [18:0] prod;
    logic [15:0] base;

    // offset in eighths of the period from the sync edge
    assign prod = 19'(per_i) * 19'(code_i); // [R2]
    assign base = prod[18:3];

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [16:0] sum;
        logic [15:0] offset;
        logic        start;
        logic [15:0] on_cnt;
        logic [16:0] acc;
        logic [16:0] next_acc;

        // second channel sits half a period behind the first
        assign sum    = {1'b0, base} + ((c == 1) ? {2'b00, per_i[15:1]} : 17'h00000);
        assign offset = (sum >= {1'b0, per_i}) ? 16'(sum - {1'b0, per_i}) : sum[15:0];
        assign start  = run_i & (cnt_i == offset); // [R2]
        assign next_acc = acc + {1'b0, on_time_i};

        // too-short pulses are banked, whole skipped cycles keep the average
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pwm_o[c] <= 1'b0;
                on_cnt   <= 16'h0000;
                acc      <= 17'h00000;
            end else if (start) begin
                if (on_time_i >= MIN_ON) begin
                    pwm_o[c] <= 1'b1;
                    on_cnt   <= on_time_i - 16'h0001;
                end else if (next_acc >= {1'b0, MIN_ON}) begin
                    pwm_o[c] <= 1'b1; // [R12]
                    on_cnt   <= MIN_ON - 16'h0001;
                    acc      <= next_acc - {1'b0, MIN_ON};
                end else begin
                    pwm_o[c] <= 1'b0; // [R12]
                    acc      <= next_acc;
                end
            end else if (pwm_o[c]) begin
                if (on_cnt == 16'h0000) begin
                    pwm_o[c] <= 1'b0;
                end else begin
                    on_cnt <= on_cnt - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/scs_top.sv
// Overview of operation
// R1: oscillator phase follows falling sync edges; rising edges are ignored.
// R2: low three bits of phase config set each channel's offset from the edge.
// R3: edge-triggered detection with fixed phase shift, never locking on harmonics.
// R4: lock is held for references between 85 kHz and 500 kHz.
// R5: lock loss in operation sets status bit 4 and pulls alert low.
// R6: lock-loss bit stays set until software writes a one to it.
// R7: masked lock fault is still recorded but does not pull alert.
// R8: without reference edges the programmed nominal period runs the switching.
// R9: external-only mode without reference runs at lowest free-running frequency.
// R10: only one device on a shared line drives sync; others listen.
// R11: driving sync while seeing an external reference drives pad bit 10 low.
// R12: on-time below the minimum makes the channel skip cycles, still regulating.
// R13: as sync source, pull the line low for 500 ns then release.
// R14: missing expected reference is detected and switching continues at own rate.
// R15: writing zero leaves the lock bit; clearing it leaves other bits alone.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "scs_regs.svh"
module scs_top (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // shared open-drain sync line
    input  wire logic        sync_i,
    output logic             sync_o,
    output logic             sync_oe_o,
    // alert and interrupt
    output logic             alert_n_o,
    output logic             irq_o,
    // channel switch drive
    output logic [1:0]       pwm_o
);
    localparam logic [15:0] PER_MIN   = 16'(`SCS_PER_MIN_CYC);
    localparam logic [15:0] PER_MAX   = 16'(`SCS_PER_MAX_CYC);
    localparam logic [15:0] TIMEOUT   = 16'(`SCS_REF_TIMEOUT_CYC);
    localparam logic [15:0] FREE_PER  = 16'(`SCS_FREERUN_PER_CYC);
    localparam logic [15:0] LOCK_TOL  = 16'(`SCS_LOCK_TOL_CYC);
    localparam logic [1:0]  LOCK_LAST = 2'(`SCS_LOCK_EDGES - 1);
    localparam logic [7:0]  PULSE_CYC = 8'(`SCS_SYNC_PULSE_CYC);

    // software state
    logic                    ctrl_run;
    logic                    ctrl_sync_out;
    logic                    ctrl_ext_only;
    scs_pkg::scs_per_t       nom_per;
    logic [2:0]              phase_code;
    scs_pkg::scs_per_t       on_time;
    logic [`SCS_ST_W-1:0]    status;
    logic [`SCS_ST_W-1:0]    mask;
    logic [`SCS_ST_W-1:0]    events;
    logic [`SCS_ST_W-1:0]    w1c;

    // bus decode
    logic                    wb_req;
    logic                    wb_wr;
    logic [31:0]             wmask;
    logic [31:0]             wdat;
    logic [31:0]             next_rdat;

    // reference tracking
    logic                    sync_fall;
    logic                    ext_fall;
    scs_pkg::scs_per_t       gap;
    scs_pkg::scs_per_t       meas_new;
    scs_pkg::scs_per_t       meas_per;
    scs_pkg::scs_per_t       diff;
    logic                    in_range;
    logic                    close;
    logic                    ref_present;
    logic                    ref_timeout;
    scs_pkg::scs_lock_e      lock_state;
    logic [1:0]              good_cnt;
    logic                    lock_lost_ev;
    logic                    ref_lost_ev;
    logic                    clash_ev;

    // oscillator and sync drive
    logic                    track;
    scs_pkg::scs_per_t       act_per;
    scs_pkg::scs_per_t       osc_cnt;
    logic [7:0]              drv_cnt;
    logic [15:0]             pads;

    scs_sync_edge u_edge (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (sync_i),
        .fall_o (sync_fall)
    );

    scs_phase_gen u_phase (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .cnt_i     (osc_cnt),
        .per_i     (act_per),
        .run_i     (ctrl_run),
        .code_i    (phase_code),
        .on_time_i (on_time),
        .pwm_o     (pwm_o)
    );

    // one-cycle request strobe; ack gap keeps each access single
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i;
    assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat   = wb_dat_i & wmask;
    assign w1c    = (wb_wr && wb_adr_i == `SCS_ADR_STATUS) ? wdat[`SCS_ST_W-1:0]
                                                            : {`SCS_ST_W{1'b0}}; // [R15]

    // wishbone ack, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdat = 32'h00000000;
        unique case (wb_adr_i)
            `SCS_ADR_CTRL: begin
                next_rdat[`SCS_CTRL_RUN]      = ctrl_run;
                next_rdat[`SCS_CTRL_SYNC_OUT] = ctrl_sync_out;
                next_rdat[`SCS_CTRL_EXT_ONLY] = ctrl_ext_only;
            end
            `SCS_ADR_NOMPER: next_rdat[15:0]            = nom_per;
            `SCS_ADR_PHASE:  next_rdat[2:0]             = phase_code;
            `SCS_ADR_ONTIME: next_rdat[15:0]            = on_time;
            `SCS_ADR_STATUS: next_rdat[`SCS_ST_W-1:0]   = status;
            `SCS_ADR_MASK:   next_rdat[`SCS_ST_W-1:0]   = mask;
            `SCS_ADR_PADS:   next_rdat[15:0]            = pads;
            `SCS_ADR_MEAS:   next_rdat[15:0]            = meas_per;
            default:         next_rdat                  = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= next_rdat;
        end
    end

    // writable settings, honouring byte enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_run      <= 1'b0;
            ctrl_sync_out <= 1'b0;
            ctrl_ext_only <= 1'b0;
            nom_per       <= `SCS_NOMPER_RST;
            phase_code    <= `SCS_PHASE_RST;
            on_time       <= `SCS_ONTIME_RST;
            mask          <= {`SCS_ST_W{1'b0}};
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                `SCS_ADR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ctrl_run      <= wb_dat_i[`SCS_CTRL_RUN];
                        ctrl_sync_out <= wb_dat_i[`SCS_CTRL_SYNC_OUT]; // [R10]
                        ctrl_ext_only <= wb_dat_i[`SCS_CTRL_EXT_ONLY];
                    end
                end
                `SCS_ADR_NOMPER: nom_per    <= (nom_per & ~wmask[15:0]) | wdat[15:0];
                `SCS_ADR_PHASE:  phase_code <= wb_sel_i[0] ? wb_dat_i[2:0] : phase_code; // [R2]
                `SCS_ADR_ONTIME: on_time    <= (on_time & ~wmask[15:0]) | wdat[15:0];
                `SCS_ADR_MASK: begin
                    mask <= (mask & ~wmask[`SCS_ST_W-1:0]) | wdat[`SCS_ST_W-1:0]; // [R7]
                end
                default: ;
            endcase
        end
    end

    // only falls we did not cause ourselves count as a reference
    assign ext_fall    = sync_fall & ~sync_oe_o;
    assign meas_new    = gap + 16'h0001;
    assign diff        = (meas_new >= meas_per) ? meas_new - meas_per : meas_per - meas_new;
    assign in_range    = (meas_new >= PER_MIN) && (meas_new <= PER_MAX); // [R4]
    assign close       = diff <= LOCK_TOL;
    assign ref_present = gap < TIMEOUT;
    assign ref_timeout = (gap == TIMEOUT - 16'h0001) && !ext_fall; // [R14]

    // period between falling edges, saturating when the line goes quiet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap      <= TIMEOUT;
            meas_per <= 16'h0000;
        end else if (ext_fall) begin
            gap      <= 16'h0000;
            meas_per <= meas_new; // [R3]
        end else if (gap != TIMEOUT) begin
            gap <= gap + 16'h0001;
        end
    end

    // lock detection: period measured from edges, so no harmonic can pass
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_state   <= scs_pkg::SCS_NOREF;
            good_cnt     <= 2'b00;
            lock_lost_ev <= 1'b0;
            ref_lost_ev  <= 1'b0;
        end else begin
            lock_lost_ev <= 1'b0;
            ref_lost_ev  <= 1'b0;
            unique case (lock_state)
                scs_pkg::SCS_NOREF: begin
                    good_cnt <= 2'b00;
                    if (ext_fall && in_range) begin
                        lock_state <= scs_pkg::SCS_ACQ; // [R4]
                    end
                end
                scs_pkg::SCS_ACQ: begin
                    if (ref_timeout) begin
                        lock_state  <= scs_pkg::SCS_NOREF;
                        ref_lost_ev <= 1'b1; // [R14]
                    end else if (ext_fall) begin
                        if (in_range && close) begin
                            if (good_cnt == LOCK_LAST) begin
                                lock_state <= scs_pkg::SCS_LOCK; // [R3]
                            end else begin
                                good_cnt <= good_cnt + 2'b01;
                            end
                        end else begin
                            good_cnt <= 2'b00;
                        end
                    end
                end
                scs_pkg::SCS_LOCK: begin
                    good_cnt <= 2'b00;
                    if (ref_timeout) begin
                        lock_state   <= scs_pkg::SCS_NOREF;
                        ref_lost_ev  <= 1'b1;
                        lock_lost_ev <= ctrl_run & ~ctrl_sync_out; // [R5]
                    end else if (ext_fall && !(in_range && close)) begin
                        lock_state   <= scs_pkg::SCS_ACQ;
                        lock_lost_ev <= ctrl_run & ~ctrl_sync_out; // [R5]
                    end
                end
                default: lock_state <= scs_pkg::SCS_NOREF;
            endcase
        end
    end

    // a source that also hears a foreign edge reports the clash
    assign clash_ev = ctrl_sync_out & ext_fall; // [R11]

    always_comb begin
        events                     = {`SCS_ST_W{1'b0}};
        events[`SCS_ST_REF_LOST]   = ref_lost_ev;
        events[`SCS_ST_CLASH]      = clash_ev;
        events[`SCS_ST_LOCK_LOST]  = lock_lost_ev; // [R5]
    end

    // sticky status: new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= {`SCS_ST_W{1'b0}};
        end else begin
            status <= (status & ~w1c) | events; // [R6] [R15]
        end
    end

    // alert low and irq high while any unmasked bit is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alert_n_o <= 1'b1;
            irq_o     <= 1'b0;
        end else begin
            alert_n_o <= ~|(((status & ~w1c) | events) & ~mask); // [R5] [R7]
            irq_o     <= |(((status & ~w1c) | events) & ~mask);
        end
    end

    // period source: tracked reference, else fallback
    assign track = ~ctrl_sync_out && (lock_state != scs_pkg::SCS_NOREF);

    always_comb begin
        if (track) begin
            act_per = meas_per; // [R1]
        end else if (ctrl_ext_only) begin
            act_per = FREE_PER; // [R9]
        end else begin
            act_per = nom_per; // [R8] [R14]
        end
    end

    // switching oscillator, restarted by every tracked falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_cnt <= 16'h0000;
        end else if (track && ext_fall) begin
            osc_cnt <= 16'h0000; // [R1] [R3]
        end else if (osc_cnt >= act_per - 16'h0001) begin
            osc_cnt <= 16'h0000;
        end else begin
            osc_cnt <= osc_cnt + 16'h0001;
        end
    end

    // sync source: fixed low pulse at the start of each period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_oe_o <= 1'b0;
            drv_cnt   <= 8'h00;
        end else if (!sync_oe_o) begin
            if (ctrl_sync_out && ctrl_run && osc_cnt == 16'h0000) begin
                sync_oe_o <= 1'b1; // [R13]
                drv_cnt   <= PULSE_CYC - 8'h01;
            end
        end else if (drv_cnt == 8'h00) begin
            sync_oe_o <= 1'b0; // [R13]
        end else begin
            drv_cnt <= drv_cnt - 8'h01;
        end
    end

    // open drain: the data side is always low
    always_ff @(posedge clk_i) begin
        sync_o <= 1'b0;
    end

    // pad report; clash bit is active low
    always_comb begin
        pads                       = 16'h0000;
        pads[`SCS_PAD_REF_PRESENT] = ref_present;
        pads[`SCS_PAD_LOCKED]      = lock_state == scs_pkg::SCS_LOCK;
        pads[`SCS_PAD_DRIVING]     = sync_oe_o;
        pads[`SCS_PAD_CLASH_N]     = ~(ctrl_sync_out & ref_present); // [R11]
    end
endmodule
`default_nettype wire

// File: verif/scs_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module scs_top_asserts (
    // system
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic        sync_o,
    input wire logic        sync_oe_o,
    input wire logic        alert_n_o,
    input wire logic        irq_o,
    input wire logic [1:0]  pwm_o
);
    logic [7:0]  oe_cnt;
    logic [15:0] on_cnt;
    logic        rd;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a read that the slave will take at this edge
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // length of the current sync pull
    always_ff @(posedge clk_i) begin
        oe_cnt <= (rst_i || !sync_oe_o) ? 8'h00 : oe_cnt + 8'h01;
    end

    // length of the current channel 0 drive; wraps only after 65536 cycles
    always_ff @(posedge clk_i) begin
        on_cnt <= (rst_i || !pwm_o[0]) ? 16'h0000 : on_cnt + 16'h0001;
    end

    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    unmapped_zero_a: assert property (rd && wb_adr_i > 8'h1C |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    phase_width_a: assert property (rd && wb_adr_i == 8'h08 |=> wb_dat_o[31:3] == 29'h0)
        else $error("phase code wider than three bits");
    status_bits_a: assert property (rd && wb_adr_i == 8'h10 |=>
        wb_dat_o[31:5] == 27'h0 && wb_dat_o[3:2] == 2'h0)
        else $error("status has undefined bits set");
    alert_irq_a: assert property (irq_o == !alert_n_o)
        else $error("irq and alert disagree");
    alert_sticky_a: assert property (!alert_n_o && !(wb_cyc_i && wb_stb_i && wb_we_i)
        |=> !alert_n_o)
        else $error("alert released without a write");
    sync_data_a: assert property (sync_o == 1'b0)
        else $error("sync data not low");
    pulse_len_a: assert property ($fell(sync_oe_o) |-> oe_cnt == 8'd50)
        else $error("sync pull not 50 cycles");
    on_min_a: assert property ($fell(pwm_o[0]) |-> on_cnt >= 16'd5)
        else $error("drive pulse below minimum");
endmodule

bind scs_top scs_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .alert_n_o(alert_n_o),
    .irq_o(irq_o), .pwm_o(pwm_o));
`default_nettype wire

// File: verif/scs_sync_partner.sv
`timescale 1ns/10ps
`default_nettype none
module scs_sync_partner (
    // control from the bench
    input  wire logic        en_i,
    input  wire logic [15:0] per_ns_i,
    // open-drain pull
    output logic             pull_o
);
    int low_ns;

    // one pull per period while enabled; very short periods get a half-period low
    initial begin
        pull_o = 1'b0;
        forever begin
            if (en_i) begin
                low_ns = (per_ns_i < 16'd1000) ? per_ns_i / 2 : 500;
                pull_o = 1'b1; // falling edge is the reference
                #(low_ns);
                pull_o = 1'b0; // released, pull-up takes the line high
                #(per_ns_i - low_ns);
            end else begin
                #40;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "scs_regs.svh"
module tb_top;
    logic        clk_i, rst_i, cyc, stb, we, wb_ack_o, sync_o, sync_oe_o;
    logic        alert_n_o, irq_o, p_en, p_pull;
    logic [7:0]  adr;
    logic [31:0] dat, rdat, wb_dat_o, r;
    logic [1:0]  pwm_o;
    logic [15:0] p_per;
    wire logic   sync_line;
    int          miscompares, n_compared, d;
    logic [31:0] rst_tab [6] = '{32'h0, 32'h190, 32'h0, 32'h28, 32'h0, 32'h0};

    // open-drain line with pull-up: low if anyone pulls
    assign sync_line = !((sync_oe_o && !sync_o) || p_pull);

    scs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sync_i(sync_line), .sync_o(sync_o), .sync_oe_o(sync_oe_o),
        .alert_n_o(alert_n_o), .irq_o(irq_o), .pwm_o(pwm_o));
    scs_sync_partner u_far (.en_i(p_en), .per_ns_i(p_per), .pull_o(p_pull));

    // 100 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] exp_w1c(input logic [31:0] old, input logic [31:0] w);
        return old & ~w;
    endfunction

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    // classic single cycle; waits for ack with no cycle limit of its own
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= v;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk_reg(rdat, e);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // cycles between two later rises of channel 0
    task automatic period(output int p);
        int n, rs, t;
        logic prev;
        n = 0;
        rs = 0;
        t = 0;
        prev = 1'b1;
        while (rs < 3 && n < 8000) begin
            @(posedge clk_i);
            n++;
            if (pwm_o[0] === 1'b1 && prev !== 1'b1) rs++;
            if (rs == 2 && t == 0) t = n;
            prev = pwm_o[0];
        end
        p = n - t;
    endtask

    // cycles from a line fall to the next channel 0 rise
    task automatic offset(output int o);
        while (sync_line !== 1'b1) @(posedge clk_i);
        while (sync_line !== 1'b0) @(posedge clk_i);
        o = 0;
        while (pwm_o[0] !== 1'b1 && o < 2000) begin
            @(posedge clk_i);
            o++;
        end
    endtask

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, p_en} = 4'h0;
        adr = 8'h00;
        dat = 32'h0;
        p_per = 16'd4000;
        void'($urandom(32'h5994e411));
        cycles(20);
        rst_i <= 1'b0;
        cycles(1);
        for (int i = 0; i < 6; i++) rd(8'(i * 4), rst_tab[i]);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0);
        $display("test reset done");
        repeat (8) begin
            r = $urandom;
            wb(1'b1, `SCS_ADR_PHASE, r);
            rd(`SCS_ADR_PHASE, {29'h0, r[2:0]});
            wb(1'b1, `SCS_ADR_NOMPER, {16'h0, r[31:16]});
            rd(`SCS_ADR_NOMPER, {16'h0, r[31:16]});
        end
        $display("test random done");
        wb(1'b1, `SCS_ADR_NOMPER, 32'd300);
        wb(1'b1, `SCS_ADR_CTRL, 32'h1);
        period(d);
        chk_reg(d, 32'd300);
        wb(1'b1, `SCS_ADR_ONTIME, 32'h2);
        period(d);
        chk_reg(d, 32'd900);
        wb(1'b1, `SCS_ADR_ONTIME, 32'h28);
        wb(1'b1, `SCS_ADR_CTRL, 32'h5);
        period(d);
        chk_reg(d, `SCS_FREERUN_PER_CYC);
        $display("test no reference done");
        wb(1'b1, `SCS_ADR_CTRL, 32'h1);
        p_per <= 16'd5000;
        p_en <= 1'b1;
        cycles(3000);
        wb(1'b0, `SCS_ADR_PADS, 32'h0);
        chk_pin(rdat[1], 1'b1);
        period(d);
        chk_reg(d, 32'd500);
        rd(`SCS_ADR_MEAS, 32'd500);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, `SCS_ADR_PHASE, c);
            offset(d);
            chk_pin(d >= 500 * c / 8 && d <= 500 * c / 8 + 6, 1'b1);
        end
        $display("test lock done");
        p_en <= 1'b0;
        cycles(3000);
        rd(`SCS_ADR_STATUS, 32'h11);
        chk_pin(alert_n_o, 1'b0);
        period(d);
        chk_reg(d, 32'd300);
        wb(1'b1, `SCS_ADR_STATUS, 32'h0);
        rd(`SCS_ADR_STATUS, 32'h11);
        wb(1'b1, `SCS_ADR_STATUS, 32'h10);
        rd(`SCS_ADR_STATUS, exp_w1c(32'h11, 32'h10));
        chk_pin(irq_o, 1'b1);
        wb(1'b1, `SCS_ADR_STATUS, 32'h1);
        chk_pin(alert_n_o, 1'b1);
        $display("test loss done");
        wb(1'b1, `SCS_ADR_MASK, 32'h13);
        p_en <= 1'b1;
        cycles(3000);
        p_en <= 1'b0;
        cycles(3000);
        rd(`SCS_ADR_STATUS, 32'h11);
        chk_pin(alert_n_o, 1'b1);
        wb(1'b1, `SCS_ADR_STATUS, 32'h13);
        wb(1'b1, `SCS_ADR_MASK, 32'h0);
        $display("test mask done");
        wb(1'b1, `SCS_ADR_CTRL, 32'h3);
        cycles(1000);
        while (sync_oe_o !== 1'b1) @(posedge clk_i);
        wb(1'b0, `SCS_ADR_PADS, 32'h0);
        chk_pin(rdat[10], 1'b1);
        chk_pin(rdat[2], 1'b1);
        p_en <= 1'b1;
        cycles(3000);
        wb(1'b0, `SCS_ADR_PADS, 32'h0);
        chk_pin(rdat[10], 1'b0);
        p_en <= 1'b0;
        $display("test source done");
        wb(1'b1, `SCS_ADR_CTRL, 32'h1);
        p_per <= 16'd80;
        p_en <= 1'b1;
        cycles(2000);
        wb(1'b0, `SCS_ADR_PADS, 32'h0);
        chk_pin(rdat[1], 1'b0);
        p_en <= 1'b0;
        $display("test fast link done");
        complete_run();
    end

    // hang guard, well beyond the expected run
    initial begin
        #900000;
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
